/* hdl/rtc_seq.sv */
// Reset sequencer: start-up delays, reset-cause flags, resume or vector decision.
// Assumes core strobes are on i_clk; pins and the RC timebase are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module rtc_seq
  import rtc_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_LIMIT = POWERUP_DELAY_TIMER_TICKS
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Pins and analog detectors
  input  wire logic       i_master_clear_pin_n,
  input  wire logic       i_osc_amp_ok,
  input  wire logic       i_rc_timebase,
  // Core events
  input  wire logic       i_sleep_instr,
  input  wire logic       i_watchdog_timer_expired,
  input  wire logic       i_watchdog_clear_instr,
  input  wire logic       i_irq_wake,
  input  wire logic       i_global_irq_disable,
  input  wire logic       i_ext_exec,
  input  wire logic       i_core_ale,
  input  wire logic       i_core_oe_n,
  input  wire logic       i_core_wr_n,
  // Core control
  output logic            o_core_reset,
  output logic            o_phase_one_hold,
  output logic            o_pc_load,
  output logic            o_pc_resume,
  output logic            o_vector_req,
  output logic            o_ale,
  output logic            o_oe_n,
  output logic            o_wr_n,
  // Avalon-MM slave
  input  wire logic [7:0] i_avs_address,
  input  wire logic       i_avs_read,
  input  wire logic       i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]     o_avs_readdata,
  output logic            o_avs_waitrequest,
  // Interrupt
  output logic            o_irq
);
  typedef enum logic [2:0] {
    ST_POR, ST_PUP, ST_MASTER_CLEAR_PIN, ST_OST, ST_HOLD, ST_RUN, ST_SLEEP
  } rtc_state_e;

  rtc_state_e      st_reg;
  logic [2:0]      s1_reg;
  logic [2:0]      s2_reg;
  logic            rc_d_reg;
  logic            master_clear_pin_hi;
  logic            to_n_reg;
  logic            pd_n_reg;
  logic            resume_reg;
  logic            vec_reg;
  logic            from_sleep_reg;
  rtc_osc_e        osc_mode_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] ev_set;
  logic            ost_mode;
  logic            rst_next;
  logic            acc;
  logic [5:0]      idx;
  logic [7:0]      cpu_flags;

  rtc_tmr_if ost_if ();
  rtc_tmr_if pwr_if ();

  // Two stages before any use; all three inputs are outside the clock domain
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_reg   <= 3'h0;
      s2_reg   <= 3'h0;
      rc_d_reg <= 1'b0;
    end else begin
      s1_reg   <= {i_rc_timebase, i_osc_amp_ok, i_master_clear_pin_n};
      s2_reg   <= s1_reg;
      rc_d_reg <= s2_reg[2];
    end
  end

  assign master_clear_pin_hi     = s2_reg[0];
  assign ost_mode    = (osc_mode_reg == OSC_CRYSTAL) || (osc_mode_reg == OSC_LOWFREQ);
  assign ost_if.tick = s2_reg[1];
  assign pwr_if.tick = s2_reg[2] && !rc_d_reg;

  rtc_tmr #(.LIMIT(OST_CYCLES)) u_osc_startup_counter (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .t      (ost_if.tmr)
  );

  rtc_tmr #(.LIMIT(POWERUP_DELAY_TIMER_LIMIT)) u_powerup_delay_timer (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .t      (pwr_if.tmr)
  );

  // Timers are launched from the sequencer state
  always_comb begin
    pwr_if.start = (st_reg == ST_POR) && master_clear_pin_hi;
    ost_if.start = ((st_reg == ST_POR) && master_clear_pin_hi)
                || ((st_reg == ST_MASTER_CLEAR_PIN) && master_clear_pin_hi && from_sleep_reg && ost_mode)
                || ((st_reg == ST_SLEEP) && master_clear_pin_hi && ost_mode
                    && (i_watchdog_timer_expired || i_irq_wake));
  end

  // Sequencer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg <= ST_POR;
    end else begin
      unique case (st_reg)
        ST_POR: begin
          if (master_clear_pin_hi) begin
            st_reg <= ST_PUP;
          end
        end
        ST_PUP: begin
          if (!master_clear_pin_hi) begin
            st_reg <= ST_POR;
          end else if (pwr_if.done && ost_if.done) begin
            st_reg <= ST_HOLD;
          end
        end
        ST_MASTER_CLEAR_PIN: begin
          if (master_clear_pin_hi) begin
            st_reg <= (from_sleep_reg && ost_mode) ? ST_OST : ST_HOLD;
          end
        end
        ST_OST: begin
          if (!master_clear_pin_hi) begin
            st_reg <= ST_MASTER_CLEAR_PIN;
          end else if (ost_if.done) begin
            st_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          st_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (!master_clear_pin_hi) begin
            st_reg <= ST_MASTER_CLEAR_PIN;
          end else if (i_watchdog_timer_expired) begin
            st_reg <= ST_HOLD;
          end else if (i_sleep_instr) begin
            st_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!master_clear_pin_hi) begin
            st_reg <= ST_MASTER_CLEAR_PIN;
          end else if (i_watchdog_timer_expired || i_irq_wake) begin
            st_reg <= ost_mode ? ST_OST : ST_HOLD;
          end
        end
        // Unused state code falls back to the power-on wait
        default: begin
          st_reg <= ST_POR;
        end
      endcase
    end
  end

  // Cause flags and release decision
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      to_n_reg       <= 1'b1;
      pd_n_reg       <= 1'b1;
      resume_reg     <= 1'b0;
      vec_reg        <= 1'b0;
      from_sleep_reg <= 1'b0;
    end else if (st_reg == ST_RUN) begin
      if (!master_clear_pin_hi) begin
        to_n_reg       <= 1'b1;
        pd_n_reg       <= 1'b1;
        resume_reg     <= 1'b0;
        vec_reg        <= 1'b0;
        from_sleep_reg <= 1'b0;
      end else if (i_watchdog_timer_expired) begin
        to_n_reg   <= 1'b0;
        pd_n_reg   <= 1'b1;
        resume_reg <= 1'b0;
        vec_reg    <= 1'b0;
      end else if (i_sleep_instr) begin
        to_n_reg <= 1'b1;
        pd_n_reg <= 1'b0;
      end else if (i_watchdog_clear_instr) begin
        to_n_reg <= 1'b1;
        pd_n_reg <= 1'b1;
      end
    end else if (st_reg == ST_SLEEP) begin
      if (!master_clear_pin_hi) begin
        to_n_reg       <= 1'b1;
        pd_n_reg       <= 1'b0;
        resume_reg     <= 1'b0;
        vec_reg        <= 1'b0;
        from_sleep_reg <= 1'b1;
      end else if (i_watchdog_timer_expired) begin
        to_n_reg   <= 1'b0;
        pd_n_reg   <= 1'b0;
        resume_reg <= 1'b0;
        vec_reg    <= 1'b0;
      end else if (i_irq_wake) begin
        to_n_reg   <= 1'b1;
        pd_n_reg   <= 1'b0;
        resume_reg <= 1'b1;
        vec_reg    <= !i_global_irq_disable;
      end
    end else if (st_reg == ST_POR) begin
      to_n_reg       <= 1'b1;
      pd_n_reg       <= 1'b1;
      resume_reg     <= 1'b0;
      vec_reg        <= 1'b0;
      from_sleep_reg <= 1'b0;
    end
  end

  // Reset and bus strobe outputs, all registered
  assign rst_next = !(((st_reg == ST_RUN) || (st_reg == ST_SLEEP)) && master_clear_pin_hi);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_core_reset     <= 1'b1;
      o_phase_one_hold <= 1'b1;
      o_ale            <= 1'b0;
      o_oe_n           <= 1'b1;
      o_wr_n           <= 1'b1;
    end else begin
      o_core_reset     <= rst_next;
      o_phase_one_hold <= rst_next;
      o_ale            <= (rst_next && i_ext_exec) ? 1'b0 : i_core_ale;
      o_oe_n           <= (rst_next && i_ext_exec) ? 1'b1 : i_core_oe_n;
      o_wr_n           <= (rst_next && i_ext_exec) ? 1'b1 : i_core_wr_n;
    end
  end

  // One-cycle release: PC zero or PC+1, and vector request after that instruction
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pc_load    <= 1'b0;
      o_pc_resume  <= 1'b0;
      o_vector_req <= 1'b0;
    end else begin
      o_pc_load    <= (st_reg == ST_HOLD);
      o_pc_resume  <= (st_reg == ST_HOLD) && resume_reg;
      o_vector_req <= (st_reg == ST_HOLD) && vec_reg;
    end
  end

  // Register bus: answer one cycle after the request is seen
  assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign idx = i_avs_address[7:2];
  assign cpu_flags = {2'h0, 1'b1, i_global_irq_disable, to_n_reg, pd_n_reg, 2'h0};

  always_comb begin
    ev_set          = '0;
    ev_set[EV_POR]  = (st_reg == ST_POR) && master_clear_pin_hi;
    ev_set[EV_MASTER_CLEAR_PIN] = ((st_reg == ST_RUN) || (st_reg == ST_SLEEP)) && !master_clear_pin_hi;
    ev_set[EV_WDT]  = ((st_reg == ST_RUN) || (st_reg == ST_SLEEP)) && master_clear_pin_hi && i_watchdog_timer_expired;
    ev_set[EV_WAKE] = (st_reg == ST_SLEEP) && master_clear_pin_hi && !i_watchdog_timer_expired && i_irq_wake;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        unique case (idx)
          IDX_CPU_FLAGS: o_avs_readdata <= {24'h0, cpu_flags};
          IDX_EVT_STAT:  o_avs_readdata <= {28'h0, stat_reg};
          IDX_EVT_MASK:  o_avs_readdata <= {28'h0, mask_reg};
          IDX_CTRL:      o_avs_readdata <= {30'h0, osc_mode_reg};
          default:       o_avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Oscillator mode and mask survive core resets; only i_srst clears them
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      osc_mode_reg <= rtc_osc_e'(RST_OSC_MODE);
      mask_reg     <= RST_MASK;
    end else if (acc && i_avs_write) begin
      if (idx == IDX_CTRL) begin
        osc_mode_reg <= rtc_osc_e'(i_avs_writedata[1:0]);
      end
      if (idx == IDX_EVT_MASK) begin
        mask_reg <= i_avs_writedata[EV_W-1:0];
      end
    end
  end

  // Read clears status; a new event in the same cycle still lands
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stat_reg <= '0;
      o_irq    <= 1'b0;
    end else begin
      if (acc && i_avs_read && (idx == IDX_EVT_STAT)) begin
        stat_reg <= ev_set;
      end else begin
        stat_reg <= stat_reg | ev_set;
      end
      o_irq <= |(stat_reg & mask_reg);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_por_delay;
    (st_reg == ST_PUP) && !(pwr_if.done && ost_if.done) |=> (st_reg != ST_RUN) && o_core_reset;
  endproperty
  a_por_delay: assert property (p_por_delay) else $error("left power-up early");

  property p_powerup_delay_timer_hold;
    (st_reg == ST_PUP) && pwr_if.busy |=> o_core_reset;
  endproperty
  a_powerup_delay_timer_hold: assert property (p_powerup_delay_timer_hold) else $error("reset dropped while power-up timer busy");

  property p_wake_fast;
    (st_reg == ST_SLEEP) && master_clear_pin_hi && i_irq_wake && !ost_mode |=> ##1 o_pc_load;
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("wake delayed without start-up mode");

  property p_master_clear_pin_run;
    (st_reg == ST_RUN) && !master_clear_pin_hi |=> to_n_reg && pd_n_reg && !resume_reg;
  endproperty
  a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("master clear flags wrong");

  property p_watchdog_clear_instr;
    (st_reg == ST_RUN) && master_clear_pin_hi && !i_watchdog_timer_expired && !i_sleep_instr
      && i_watchdog_clear_instr |=> to_n_reg && pd_n_reg;
  endproperty
  a_watchdog_clear_instr: assert property (p_watchdog_clear_instr) else $error("watchdog clear flags wrong");

  property p_wake_flags;
    (st_reg == ST_SLEEP) && master_clear_pin_hi && !i_watchdog_timer_expired && i_irq_wake
      |=> to_n_reg && !pd_n_reg ##1 o_core_reset;
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("wake flags wrong");

  property p_wdt_run;
    (st_reg == ST_RUN) && master_clear_pin_hi && i_watchdog_timer_expired
      |=> !to_n_reg && pd_n_reg ##1 o_pc_load && !o_pc_resume;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog in run wrong");

  property p_wdt_sleep;
    (st_reg == ST_SLEEP) && master_clear_pin_hi && i_watchdog_timer_expired && ost_mode
      |=> !to_n_reg && !pd_n_reg && (st_reg == ST_OST);
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog in sleep wrong");

  property p_resume;
    o_pc_load && $past(resume_reg) |-> o_pc_resume && (o_vector_req == $past(vec_reg));
  endproperty
  a_resume: assert property (p_resume) else $error("resume or vector wrong");

  property p_strobes;
    o_core_reset && $past(i_ext_exec) |-> !o_ale && o_oe_n && o_wr_n && o_phase_one_hold;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobes not parked in reset");

  property p_flag_read;
    !o_avs_waitrequest && $past(i_avs_read && (idx == IDX_CPU_FLAGS))
      |-> o_avs_readdata[B_TO:B_PD] == $past({to_n_reg, pd_n_reg});
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");
endmodule : rtc_seq
`default_nettype wire

/* hdl/rtc_tmr.sv */
// Tick counter used for the start-up and power-up delays.
// Assumes tick is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module rtc_tmr
  import rtc_pkg::*;
#(
  parameter int LIMIT = 1024
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Control
  rtc_tmr_if.tmr    t
);
  logic [TMR_W-1:0] cnt_reg;
  logic             run_reg;
  logic             done_reg;

  assign t.busy = run_reg;
  assign t.done = done_reg;

  // Counts only on ticks, so a quiet oscillator holds the count
  always_ff @(posedge i_clk) begin
    if (i_srst || t.start) begin
      cnt_reg  <= '0;
      run_reg  <= !i_srst;
      done_reg <= 1'b0;
    end else if (run_reg && t.tick) begin
      if (cnt_reg == TMR_W'(LIMIT - 1)) begin
        run_reg  <= 1'b0;
        done_reg <= 1'b1;
      end
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  property p_tick_only;
    @(posedge i_clk) disable iff (i_srst)
    (run_reg && !t.tick && !t.start) |=> (cnt_reg == $past(cnt_reg));
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("timer advanced without tick");
endmodule : rtc_tmr
`default_nettype wire

/* inc/rtc_pkg.sv */
// Constants for the reset time-out and reset-cause block.
// Assumes a 250 MHz oscillator clock and a byte-addressed Avalon-MM register bus.
package rtc_pkg;
  // Timing
  localparam int CLK_MHZ      = 250;
  localparam int OST_TOSC     = 1024;
  localparam int OST_CYCLES   = OST_TOSC;
  localparam int POWERUP_DELAY_TIMER_MS      = 96;
  localparam int RC_TICK_NS   = 1000;
  localparam int POWERUP_DELAY_TIMER_TICKS   = POWERUP_DELAY_TIMER_MS * 1000000 / RC_TICK_NS;
  localparam int TMR_W        = 24;
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_CPU_FLAGS = 6'h06;
  localparam logic [5:0] IDX_EVT_STAT  = 6'h08;
  localparam logic [5:0] IDX_EVT_MASK  = 6'h09;
  localparam logic [5:0] IDX_CTRL      = 6'h0a;
  // Field positions in cpu_state_flags
  localparam int B_PD   = 2;
  localparam int B_TO   = 3;
  localparam int B_GLD  = 4;
  localparam int B_ONE  = 5;
  // Event status bits
  localparam int EV_POR  = 0;
  localparam int EV_MASTER_CLEAR_PIN = 1;
  localparam int EV_WDT  = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_W    = 4;
  // Reset values
  localparam logic [1:0]      RST_OSC_MODE = 2'h0;
  localparam logic [EV_W-1:0] RST_MASK     = 4'h0;
  localparam logic [15:0]     RESET_VECTOR = 16'h0000;
  typedef enum logic [1:0] {
    OSC_CRYSTAL = 2'h0,
    OSC_LOWFREQ = 2'h1,
    OSC_EXTCLK  = 2'h2,
    OSC_RCOSC   = 2'h3
  } rtc_osc_e;
endpackage : rtc_pkg

/* inc/rtc_tmr_if.sv */
// Start, tick and completion signals between the sequencer and one delay timer.
// Assumes both ends share i_clk.
`timescale 1ns/1ps
`default_nettype none
interface rtc_tmr_if;
  logic start;
  logic tick;
  logic busy;
  logic done;
  modport tmr (input start, input tick, output busy, output done);
  modport ctl (output start, output tick, input busy, input done);
endinterface : rtc_tmr_if
`default_nettype wire

/* tb/rtc_master_clear_pin_model.sv */
// External reset circuit on the master clear pin: RC hold at power-up, push button.
// Assumes a pull-up on the pin, so a released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module rtc_master_clear_pin_model #(
  parameter int POR_HOLD = 50
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Button
  input  wire logic i_press,
  // Pin
  output logic      o_master_clear_pin_n
);
  int hold_cnt;
  // Capacitor keeps the pin low for a while after supply comes up
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hold_cnt <= POR_HOLD;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  always_ff @(posedge i_clk) begin
    o_master_clear_pin_n <= !(i_srst || hold_cnt != 0 || i_press);
  end
endmodule : rtc_master_clear_pin_model
`default_nettype wire

/* tb/rtc_seq_tb.sv */
// Self-checking bench for the reset sequencer, with register bus and reset pin model.
// Assumes a shortened power-up count; RC timebase at its nominal 1 us tick.
`timescale 1ns/1ps
`default_nettype none
module rtc_seq_tb;
  import rtc_pkg::*;
  // Power-up count cut from 96 ms so the run stays short
  localparam int POWERUP_DELAY_TIMER_SIM = 8;
  logic        i_clk, i_srst, press, pin_n, amp, rc_tb;
  logic        slp, wdt, clr, wake, gld, ext;
  logic [7:0]  addr;
  logic        rd, wr;
  logic [31:0] wdata, rdata, q;
  logic        core_rst, ph1, pc_load, pc_res, vec, ale, oe_n, wr_n, waitreq, irq;
  int          fail_count, cmp_count, cyc, n;

  rtc_master_clear_pin_model mdl (.i_clk(i_clk), .i_srst(i_srst), .i_press(press), .o_master_clear_pin_n(pin_n));
  rtc_seq #(.POWERUP_DELAY_TIMER_LIMIT(POWERUP_DELAY_TIMER_SIM)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_master_clear_pin_n(pin_n), .i_osc_amp_ok(amp),
    .i_rc_timebase(rc_tb), .i_sleep_instr(slp), .i_watchdog_timer_expired(wdt),
    .i_watchdog_clear_instr(clr), .i_irq_wake(wake), .i_global_irq_disable(gld),
    .i_ext_exec(ext), .i_core_ale(1'b1), .i_core_oe_n(1'b0), .i_core_wr_n(1'b0),
    .o_core_reset(core_rst), .o_phase_one_hold(ph1), .o_pc_load(pc_load), .o_pc_resume(pc_res),
    .o_vector_req(vec), .o_ale(ale), .o_oe_n(oe_n), .o_wr_n(wr_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .o_irq(irq));

  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  // RC timebase is free running and unrelated in phase to the oscillator
  initial begin
    rc_tb = 0;
    #137;
    forever #500 rc_tb = ~rc_tb;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One Avalon transfer; holds the request until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    do begin
      @(posedge i_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata;
    if (k >= 50) chk("bus_timeout", 1, 0);
    rd <= 0;
    wr <= 0;
  endtask : bus

  function automatic logic [31:0] fl(input logic g, input logic t, input logic p);
    fl = 32'h0;
    fl[B_ONE] = 1'b1;
    fl[B_GLD] = g;
    fl[B_TO]  = t;
    fl[B_PD]  = p;
  endfunction : fl

  // Event pulse: 0 sleep, 1 watchdog time-out, 2 watchdog clear, 3 wake
  task automatic ev(input int k);
    @(posedge i_clk);
    case (k)
      0: slp <= 1;
      1: wdt <= 1;
      2: clr <= 1;
      default: wake <= 1;
    endcase
    @(posedge i_clk);
    {slp, wdt, clr, wake} <= 4'h0;
  endtask : ev

  task automatic wait_pc();
    n = 0;
    while (pc_load !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    if (pc_load !== 1'b1) chk("pc_load_wait", 0, 1);
  endtask : wait_pc

  task automatic button();
    @(posedge i_clk);
    press <= 1;
    repeat (10) @(posedge i_clk);
    press <= 0;
    wait_pc();
  endtask : button

  task automatic t_powerup();
    n = 0;
    while (pin_n !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    n = 0;
    while (core_rst === 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
      if (n == 100) begin
        chk("ale_rst", ale, 0);
        chk("oe_rst", oe_n, 1);
        chk("wr_rst", wr_n, 1);
        chk("ph1_rst", ph1, 1);
      end
    end
    chk("powerup_delay_timer_min", n >= 7 * 250, 1);
    chk("powerup_delay_timer_max", n <= 8 * 250 + 60, 1);
    repeat (3) @(posedge i_clk);
    chk("ale_run", ale, 1);
    chk("oe_run", oe_n, 0);
    chk("wr_run", wr_n, 0);
    chk("ph1_run", ph1, 0);
    bus(8'h18, 0, 0);
    chk("flags_por", q, fl(1, 1, 1));
    bus(8'h20, 0, 0);
    chk("stat_por", q[EV_POR], 1);
    bus(8'h20, 0, 0);
    chk("stat_clr", q, 0);
    bus(8'h24, 0, 0);
    chk("mask_rst", q, 0);
    bus(8'h28, 0, 0);
    chk("ctrl_rst", q, 0);
    bus(8'h3c, 1, 32'h0000_00ff);
    bus(8'h3c, 0, 0);
    chk("unmapped", q, 0);
  endtask : t_powerup

  task automatic t_wdt_run();
    bus(8'h24, 1, 32'h1 << EV_WDT);
    ev(1);
    wait_pc();
    chk("wdt_fast", n <= 8, 1);
    chk("wdt_pc", pc_res, 0);
    repeat (3) @(posedge i_clk);
    chk("irq_on", irq, 1);
    bus(8'h18, 0, 0);
    chk("flags_wdt", q, fl(1, 0, 1));
    bus(8'h20, 0, 0);
    chk("stat_wdt", q, 32'h1 << EV_WDT);
    repeat (2) @(posedge i_clk);
    chk("irq_off", irq, 0);
    bus(8'h24, 1, 0);
    ev(1);
    wait_pc();
    repeat (3) @(posedge i_clk);
    chk("irq_masked", irq, 0);
    button();
    chk("master_clear_pin_fast", n <= 20, 1);
    chk("master_clear_pin_pc", pc_res, 0);
    bus(8'h18, 0, 0);
    chk("flags_master_clear_pin", q, fl(1, 1, 1));
  endtask : t_wdt_run

  task automatic t_wake(input logic [1:0] m);
    bus(8'h28, 1, {30'h0, m});
    gld <= m[0];
    repeat (5) @(posedge i_clk);
    ev(0);
    if (m == 2'h0) amp <= 0;
    repeat (5) @(posedge i_clk);
    ev(3);
    if (m == 2'h0) begin
      repeat (100) @(posedge i_clk);
      amp <= 1;
    end
    wait_pc();
    if (m == 2'h0) n = n + 100;
    if (m < 2'h2) chk("ost_wait", n >= OST_CYCLES + (m == 2'h0 ? 100 : 0), 1);
    if (m < 2'h2) chk("ost_max", n <= OST_CYCLES + 140, 1);
    else chk("no_ost", n <= 8, 1);
    chk("wake_pc", pc_res, 1);
    chk("wake_vec", vec, !m[0]);
    bus(8'h18, 0, 0);
    chk("flags_wake", q, fl(m[0], 1, 0));
  endtask : t_wake

  task automatic t_sleep_resets();
    ev(2);
    bus(8'h18, 0, 0);
    chk("flags_clr", q, fl(1, 1, 1));
    bus(8'h28, 1, 32'h0);
    ev(0);
    repeat (5) @(posedge i_clk);
    ev(1);
    wait_pc();
    chk("wdts_ost", n >= OST_CYCLES, 1);
    chk("wdts_pc", pc_res, 0);
    bus(8'h18, 0, 0);
    chk("flags_wdts", q, fl(1, 0, 0));
    repeat (5) @(posedge i_clk);
    ev(0);
    button();
    chk("mclrs_pc", pc_res, 0);
    bus(8'h18, 0, 0);
    chk("flags_mclrs", q, fl(1, 1, 0));
  endtask : t_sleep_resets

  initial begin
    {i_srst, press, amp, slp, wdt, clr, wake, gld, ext, rd, wr} = 11'h50c;
    addr  = 8'h00;
    wdata = 32'h0;
    i_srst = 1;
    repeat (20) @(posedge i_clk);
    i_srst <= 0;
    t_powerup();
    t_wdt_run();
    for (int m = 0; m < 4; m++) t_wake(m[1:0]);
    t_sleep_resets();
    finish_test();
  end
endmodule : rtc_seq_tb
`default_nettype wire
